// ===== dmacu_pkg.sv
/*
  dmacu_pkg: constants, types and register map of the transfer control
  and address block.
  Assumes a 16-bit register port decoded on the full 32-bit address.
*/
`default_nettype none
package dmacu_pkg;

  // register addresses
  localparam logic [31:0] AOUT_NEXT_HIGH_OFF = 32'h0b00002e;
  localparam logic [31:0] IR_BASE_LOW_OFF = 32'h0b000030;
  localparam logic [31:0] IR_BASE_HIGH_OFF = 32'h0b000032;
  localparam logic [31:0] IR_NEXT_LOW_OFF = 32'h0b000034;
  localparam logic [31:0] IR_NEXT_HIGH_OFF = 32'h0b000036;
  localparam logic [31:0] CTRL_RESET_OFF = 32'h0b000040;
  localparam logic [31:0] SEQ_IDLE_OFF = 32'h0b000042;
  localparam logic [31:0] SEQ_ENABLE_OFF = 32'h0b000044;
  localparam logic [31:0] CHAN_ENABLE_OFF = 32'h0b000046;
  localparam logic [31:0] CHAN_REQUEST_OFF = 32'h0b000048;
  localparam logic [31:0] IR_DIRECTION_OFF = 32'h0b00004a;

  // field positions
  localparam int FLAG_BIT = 0;
  localparam int AUDIO_IN_BIT = 3;
  localparam int AUDIO_OUT_BIT = 2;
  localparam int INFRARED_BIT = 0;
  localparam int PAGE_BIT = 10;

  // writable masks and reset values
  localparam logic [15:0] HIGH_WRITE_MASK = 16'h07ff;
  localparam logic [3:0] CHAN_MASK = 4'hd;
  localparam logic [15:0] ADDR_LOW_RESET = 16'hf800;
  localparam logic [15:0] ADDR_HIGH_RESET = 16'h01ff;
  localparam logic [31:0] PAGE_SIZE = 32'h00000400;
  localparam logic [31:0] HALF_WORD_STEP = 32'h00000002;
  localparam logic [9:0] PAGE_LAST_OFFSET = 10'h3fe;

  typedef enum logic [1:0] {
    DMACU_IDLE = 2'b00,
    DMACU_WAIT = 2'b01,
    DMACU_XFER = 2'b10,
    DMACU_GAP = 2'b11
  } dmacu_state_type;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dmacu_reg_req_type;

  // transfer side outputs towards the bus and the peripherals
  typedef struct packed {
    logic bus_req;
    logic [3:0] chan_ack;
    logic strobe;
    logic [31:0] ir_address;
    logic ir_to_memory;
  } dmacu_xfer_type;

  // software-visible registers
  typedef struct packed {
    logic [15:0] aout_next_high;
    logic [31:0] ir_base;
    logic [31:0] ir_next;
    logic controller_reset_n;
    logic sequencer_run_enable;
    logic [3:0] chan_enable;
    logic infrared_direction_bit;
  } dmacu_regs_type;

endpackage
`default_nettype wire

// ===== dmacu_top.sv
/*
  dmacu_top: transfer control unit and infrared address unit.
  Arbitrates three peripheral requests, asks the bus control unit for
  the bus, and steps the infrared next address inside its buffer.
  Assumes peripherals and bus control unit run on clk, each peripheral
  holds its request level until it sees its acknowledge, and drops it
  in the cycle after that acknowledge.
*/
// Implementation choice: the address-and-strobe port.
// Summary of operation
// - fixed order audio in, audio out, infrared
// - refresh, then bus hold, then transfers
// - refresh waits for current single transfer
// - request/acknowledge with bus unit and peripherals
// - controller held reset while bit0 is zero
// - idle flag reads one when sequencer idle
// - sequencer runs only when enable set
// - per-channel enables at bits 3, 2, 0
// - pending requests readable at bits 3, 2, 0
// - direction bit picks infrared transfer direction
// - reserved bits read zero, write zero
// - infrared base high writable bits 26:16 only
// - base address becomes transfer start address
// - channel confined to 2 Kbyte buffer
// - next infrared address kept in address registers
// - audio out next address high, eleven bits
// - start in first page: jump plus 1K
// - start in second page: jump minus 1K
`timescale 1ns/100ps
`default_nettype none
module dmacu_top
  import dmacu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire dmacu_reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  input wire logic audio_in_request,
  input wire logic audio_out_request,
  input wire logic infrared_request,
  input wire logic refresh_request,
  input wire logic hold_request,
  input wire logic bus_ack,
  output dmacu_xfer_type xfer
);

  typedef struct packed {
    dmacu_state_type state;
    dmacu_regs_type regs;
    logic [3:0] pending;
    logic [3:0] sel;
    logic [15:0] rdata;
    dmacu_xfer_type xfer;
  } dmacu_all_type;

  dmacu_all_type cur;
  dmacu_all_type next_cur;

  // address match on the full register address
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // one-hot pick of the winning channel, fixed order
  function automatic logic [3:0] pick(input logic [3:0] elig);
    pick = 4'h0;
    if (elig[AUDIO_IN_BIT]) begin
      pick[AUDIO_IN_BIT] = 1'b1;
    end else if (elig[AUDIO_OUT_BIT]) begin
      pick[AUDIO_OUT_BIT] = 1'b1;
    end else if (elig[INFRARED_BIT]) begin
      pick[INFRARED_BIT] = 1'b1;
    end
  endfunction

  // next half-word address with page wrap inside the buffer
  function automatic logic [31:0] step(input logic [31:0] a, input logic [31:0] b);
    step = a + HALF_WORD_STEP;
    if (a[PAGE_BIT-1:0] == PAGE_LAST_OFFSET) begin
      if (a[PAGE_BIT] == b[PAGE_BIT]) begin
        // end of start page: move to the other page of the buffer
        if (b[PAGE_BIT]) begin
          step = b - PAGE_SIZE;
        end else begin
          step = b + PAGE_SIZE;
        end
      end else begin
        step = b;
      end
    end
  endfunction

  logic [3:0] req_now;
  logic run_ok;
  logic [3:0] eligible;
  logic bus_busy;

  // request vector laid out like the request register
  assign req_now = {audio_in_request, audio_out_request, 1'b0, infrared_request};
  assign run_ok = cur.regs.controller_reset_n & cur.regs.sequencer_run_enable;
  assign eligible = cur.pending & cur.regs.chan_enable & CHAN_MASK;
  assign bus_busy = refresh_request | hold_request;

  always_comb begin
    next_cur = cur;
    next_cur.rdata = 16'h0000;
    next_cur.xfer.chan_ack = 4'h0;
    next_cur.xfer.strobe = 1'b0;
    next_cur.pending = req_now;

    // register writes, reserved bits dropped
    if (reg_req.wr) begin
      if (hit(reg_req.addr, AOUT_NEXT_HIGH_OFF)) begin
        next_cur.regs.aout_next_high = reg_req.wdata & HIGH_WRITE_MASK;
      end
      if (hit(reg_req.addr, IR_BASE_LOW_OFF)) begin
        next_cur.regs.ir_base[15:0] = reg_req.wdata;
        next_cur.regs.ir_next[15:0] = reg_req.wdata;
      end
      if (hit(reg_req.addr, IR_BASE_HIGH_OFF)) begin
        next_cur.regs.ir_base[31:16] = reg_req.wdata & HIGH_WRITE_MASK;
        next_cur.regs.ir_next[31:16] = reg_req.wdata & HIGH_WRITE_MASK;
      end
      if (hit(reg_req.addr, IR_NEXT_LOW_OFF)) begin
        next_cur.regs.ir_next[15:0] = reg_req.wdata;
      end
      if (hit(reg_req.addr, IR_NEXT_HIGH_OFF)) begin
        next_cur.regs.ir_next[31:16] = reg_req.wdata & HIGH_WRITE_MASK;
      end
      if (hit(reg_req.addr, CTRL_RESET_OFF)) begin
        next_cur.regs.controller_reset_n = reg_req.wdata[FLAG_BIT];
      end
      if (hit(reg_req.addr, SEQ_ENABLE_OFF)) begin
        next_cur.regs.sequencer_run_enable = reg_req.wdata[FLAG_BIT];
      end
      if (hit(reg_req.addr, CHAN_ENABLE_OFF)) begin
        next_cur.regs.chan_enable = reg_req.wdata[3:0] & CHAN_MASK;
      end
      if (hit(reg_req.addr, IR_DIRECTION_OFF)) begin
        next_cur.regs.infrared_direction_bit = reg_req.wdata[FLAG_BIT];
      end
    end

    // register reads, data valid in the following cycle only
    if (reg_req.rd) begin
      if (hit(reg_req.addr, AOUT_NEXT_HIGH_OFF)) begin
        next_cur.rdata = cur.regs.aout_next_high;
      end
      if (hit(reg_req.addr, IR_BASE_LOW_OFF)) begin
        next_cur.rdata = cur.regs.ir_base[15:0];
      end
      if (hit(reg_req.addr, IR_BASE_HIGH_OFF)) begin
        next_cur.rdata = cur.regs.ir_base[31:16];
      end
      if (hit(reg_req.addr, IR_NEXT_LOW_OFF)) begin
        next_cur.rdata = cur.regs.ir_next[15:0];
      end
      if (hit(reg_req.addr, IR_NEXT_HIGH_OFF)) begin
        next_cur.rdata = cur.regs.ir_next[31:16];
      end
      if (hit(reg_req.addr, CTRL_RESET_OFF)) begin
        next_cur.rdata = {15'h0000, cur.regs.controller_reset_n};
      end
      if (hit(reg_req.addr, SEQ_IDLE_OFF)) begin
        next_cur.rdata = {15'h0000, cur.state == DMACU_IDLE};
      end
      if (hit(reg_req.addr, SEQ_ENABLE_OFF)) begin
        next_cur.rdata = {15'h0000, cur.regs.sequencer_run_enable};
      end
      if (hit(reg_req.addr, CHAN_ENABLE_OFF)) begin
        next_cur.rdata = {12'h000, cur.regs.chan_enable};
      end
      if (hit(reg_req.addr, CHAN_REQUEST_OFF)) begin
        next_cur.rdata = {12'h000, cur.pending & CHAN_MASK};
      end
      if (hit(reg_req.addr, IR_DIRECTION_OFF)) begin
        next_cur.rdata = {15'h0000, cur.regs.infrared_direction_bit};
      end
    end

    // transfer sequencer
    case (cur.state)
      DMACU_IDLE: begin
        next_cur.xfer.bus_req = 1'b0;
        if (run_ok && (eligible != 4'h0) && !bus_busy) begin
          next_cur.sel = pick(eligible);
          next_cur.xfer.bus_req = 1'b1;
          next_cur.state = DMACU_WAIT;
        end
      end
      DMACU_WAIT: begin
        if (!run_ok || bus_busy) begin
          // refresh or hold arrived before the grant: step back
          next_cur.xfer.bus_req = 1'b0;
          next_cur.state = DMACU_IDLE;
        end else if (bus_ack) begin
          next_cur.xfer.chan_ack = cur.sel;
          next_cur.xfer.strobe = 1'b1;
          next_cur.state = DMACU_XFER;
        end
      end
      DMACU_XFER: begin
        // the single transfer ends here even if refresh is waiting
        next_cur.xfer.bus_req = 1'b0;
        if (cur.sel[INFRARED_BIT]) begin
          next_cur.regs.ir_next = step(cur.regs.ir_next, cur.regs.ir_base);
        end
        next_cur.state = DMACU_GAP;
      end
      DMACU_GAP: begin
        // lets the served peripheral drop its request first
        next_cur.state = DMACU_IDLE;
      end
      default: begin
        next_cur.xfer.bus_req = 1'b0;
        next_cur.state = DMACU_IDLE;
      end
    endcase

    // controller reset aborts any sequence
    if (!cur.regs.controller_reset_n) begin
      next_cur.state = DMACU_IDLE;
      next_cur.xfer.bus_req = 1'b0;
      next_cur.xfer.chan_ack = 4'h0;
      next_cur.xfer.strobe = 1'b0;
    end

    next_cur.xfer.ir_address = next_cur.regs.ir_next;
    next_cur.xfer.ir_to_memory = next_cur.regs.infrared_direction_bit;
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur.state <= DMACU_IDLE;
      cur.regs.aout_next_high <= ADDR_HIGH_RESET;
      cur.regs.ir_base <= {ADDR_HIGH_RESET, ADDR_LOW_RESET};
      cur.regs.ir_next <= {ADDR_HIGH_RESET, ADDR_LOW_RESET};
      cur.regs.controller_reset_n <= 1'b0;
      cur.regs.sequencer_run_enable <= 1'b0;
      cur.regs.chan_enable <= 4'h0;
      cur.regs.infrared_direction_bit <= 1'b0;
      cur.pending <= 4'h0;
      cur.sel <= 4'h0;
      cur.rdata <= 16'h0000;
      cur.xfer.bus_req <= 1'b0;
      cur.xfer.chan_ack <= 4'h0;
      cur.xfer.strobe <= 1'b0;
      cur.xfer.ir_address <= {ADDR_HIGH_RESET, ADDR_LOW_RESET};
      cur.xfer.ir_to_memory <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign reg_rdata = cur.rdata;
  assign xfer = cur.xfer;

endmodule
`default_nettype wire

// ===== dmacu_checker.sv
/*
  dmacu_checker: port assertions for dmacu_top.
  Assumes it is bound onto dmacu_top, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module dmacu_checker
  import dmacu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire dmacu_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic refresh_request,
  input wire logic hold_request,
  input wire logic bus_ack,
  input wire dmacu_xfer_type xfer
);
  logic rstn;
  logic run;
  logic [3:0] en;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadow of the control bits written by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstn <= 1'b0;
      run <= 1'b0;
      en <= 4'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == CTRL_RESET_OFF) rstn <= reg_req.wdata[0];
      if (reg_req.addr == SEQ_ENABLE_OFF) run <= reg_req.wdata[0];
      if (reg_req.addr == CHAN_ENABLE_OFF) en <= reg_req.wdata[3:0] & CHAN_MASK;
    end
  end
  property p_grant; xfer.strobe |-> $past(bus_ack) && $past(xfer.bus_req); endproperty
  a_grant: assert property (p_grant) else $error("strobe without grant");
  property p_onehot; (xfer.strobe || xfer.chan_ack != 4'h0) |-> xfer.strobe && $onehot(xfer.chan_ack)
    && (xfer.chan_ack & ~en) == 4'h0; endproperty
  a_onehot: assert property (p_onehot) else $error("bad channel ack");
  property p_yield; xfer.bus_req && (refresh_request || hold_request) |=> !xfer.bus_req; endproperty
  a_yield: assert property (p_yield) else $error("bus request kept");
  property p_gap; xfer.strobe |=> (!xfer.strobe && !xfer.bus_req) [*2]; endproperty
  a_gap: assert property (p_gap) else $error("more than one transfer");
  property p_rsv; $past(reg_req.rd) && $past(reg_req.addr) >= CTRL_RESET_OFF && $past(reg_req.addr) <=
    IR_DIRECTION_OFF |-> reg_rdata[15:4] == 12'h000 && !reg_rdata[1]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_run; $rose(xfer.bus_req) |-> $past(rstn && run); endproperty
  a_run: assert property (p_run) else $error("request while stopped");
  property p_dir; $past(reg_req.wr) && $past(reg_req.addr) == IR_DIRECTION_OFF |->
    xfer.ir_to_memory == $past(reg_req.wdata[0]); endproperty
  a_dir: assert property (p_dir) else $error("direction not taken");
  property p_step; xfer.strobe && xfer.chan_ack[0] && xfer.ir_address[9:0] != PAGE_LAST_OFFSET |=>
    xfer.ir_address == $past(xfer.ir_address) + HALF_WORD_STEP; endproperty
  a_step: assert property (p_step) else $error("address step wrong");
endmodule
bind dmacu_top dmacu_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .refresh_request(refresh_request), .hold_request(hold_request),
  .bus_ack(bus_ack), .xfer(xfer));
`default_nettype wire

// ===== dmacu_peer.sv
/*
  dmacu_peer: peripheral units and bus control unit model.
  Assumes dmacu_top on the same clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dmacu_peer
  import dmacu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] go,
  input wire logic slow,
  input wire logic refresh_request,
  input wire logic hold_request,
  input wire dmacu_xfer_type xfer,
  output logic [2:0] req,
  output logic bus_ack
);
  logic [2:0] n;
  // requests held until acked, grant after an optional wait
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req <= 3'h0;
      n <= 3'h0;
      bus_ack <= 1'b0;
    end else begin
      req <= (req | go) & ~{xfer.chan_ack[3:2], xfer.chan_ack[0]};
      n <= xfer.bus_req ? n + {2'h0, n != 3'h7} : 3'h0;
      bus_ack <= xfer.bus_req && !xfer.strobe && !refresh_request && !hold_request
        && n >= (slow ? 3'h4 : 3'h0);
    end
  end
endmodule
`default_nettype wire

// ===== tb_dma_control_and_address.sv
/*
  tb_dma_control_and_address: self-checking bench for dmacu_top.
  Assumes dmacu_peer stands in for peripherals and bus unit.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_dma_control_and_address
  import dmacu_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b0;
  logic refr = 1'b0;
  logic hold = 1'b0;
  logic bus_ack;
  logic [2:0] go = 3'h0;
  logic [2:0] req;
  logic [15:0] rdata;
  dmacu_reg_req_type rq = '0;
  dmacu_xfer_type xfer;
  int n_fail = 0;
  int check_count = 0;
  dmacu_top uut (.clk(clk), .sys_rst(sys_rst), .reg_req(rq), .reg_rdata(rdata), .audio_in_request(req[2]),
    .audio_out_request(req[1]), .infrared_request(req[0]), .refresh_request(refr), .hold_request(hold),
    .bus_ack(bus_ack), .xfer(xfer));
  dmacu_peer peer (.clk(clk), .sys_rst(sys_rst), .go(go), .slow(slow), .refresh_request(refr),
    .hold_request(hold), .xfer(xfer), .req(req), .bus_ack(bus_ack));
  // free-running clock
  initial begin
    forever #5 clk = ~clk;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    rq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk);
    rq <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    rq.rd <= 1'b0;
    #1 cmp({16'h0, rdata}, {16'h0, e});
  endtask
  task pulse(input logic [2:0] g);
    @(posedge clk);
    go <= g;
    @(posedge clk);
    go <= 3'h0;
  endtask
  task ws(input logic [3:0] e);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 60 && c == 4'h0; i++) begin
      @(posedge clk);
      #1 c = xfer.strobe === 1'b1 ? xfer.chan_ack : 4'h0;
    end
    cmp({28'h0, c}, {28'h0, e});
  endtask
  task t_regs;
    logic [7:0] off [11];
    logic [15:0] r1 [11];
    off = '{8'h2e, 8'h30, 8'h32, 8'h34, 8'h36, 8'h40, 8'h44, 8'h46, 8'h48, 8'h4a, 8'h38};
    r1 = '{16'h07fe, 16'hfffe, 16'h01fe, 16'hfffe, 16'h07fe, 16'h1, 16'h1, 16'hd, 16'h0, 16'h1, 16'h0};
    foreach (off[i]) rd({24'h0b0000, off[i]}, off[i] < 8'h37 && off[i][1] ? 16'h01ff : off[i] < 8'h37 ? 16'hf800 : 16'h0);
    foreach (off[i]) begin
      wr({24'h0b0000, off[i]}, off[i] == 8'h48 || off[i] == 8'h38 ? 16'h000d : r1[i]);
      rd({24'h0b0000, off[i]}, r1[i]);
    end
    rd(SEQ_IDLE_OFF, 16'h1);
  endtask
  task t_pend;
    wr(SEQ_ENABLE_OFF, 16'h0);
    pulse(3'h7);
    rd(CHAN_REQUEST_OFF, 16'hd);
    rd(SEQ_IDLE_OFF, 16'h1);
    cmp({31'h0, xfer.bus_req}, 32'h0);
    wr(SEQ_ENABLE_OFF, 16'h1);
    ws(4'h8);
    ws(4'h4);
    ws(4'h1);
  endtask
  task t_wrap(input logic [15:0] b);
    logic [31:0] e;
    e = {16'h0, b};
    wr(IR_BASE_HIGH_OFF, 16'h0);
    wr(IR_BASE_LOW_OFF, b);
    rd(IR_NEXT_LOW_OFF, b);
    wr(IR_DIRECTION_OFF, {15'h0, b[10]});
    #1 cmp({31'h0, xfer.ir_to_memory}, {31'h0, b[10]});
    repeat (5) begin
      @(posedge clk);
      #1 cmp(xfer.ir_address, e);
      pulse(3'h1);
      ws(4'h1);
      e = e[9:0] != 10'h3fe ? e + 32'h2 : e[10] != b[10] ? {16'h0, b} : {16'h0, b[15:11], ~b[10], b[9:0]};
    end
  endtask
  task t_yield;
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulse(3'h2);
      for (int i = 0; i < 20 && xfer.bus_req !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      refr <= k == 0;
      hold <= k == 1;
      repeat (3) @(posedge clk);
      #1 cmp({31'h0, xfer.bus_req}, 32'h0);
      @(posedge clk);
      refr <= 1'b0;
      hold <= 1'b0;
      ws(4'h4);
    end
    slow <= 1'b0;
  endtask
  task t_off;
    wr(CHAN_ENABLE_OFF, 16'hc);
    wr(CTRL_RESET_OFF, 16'h0);
    pulse(3'h3);
    ws(4'h0);
    wr(CTRL_RESET_OFF, 16'h1);
    ws(4'h4);
    ws(4'h0);
    rd(CHAN_REQUEST_OFF, 16'h1);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_pend;
    t_wrap(16'h03fc);
    t_wrap(16'h07fc);
    t_yield;
    t_off;
    stop_test;
  end
  // watchdog
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
